/* File: tms_pkg.sv */
// Types shared by the test-mode block.
// Assumes tms_regs.svh is on the include path.
`include "tms_regs.svh"
package tms_pkg;

  // Decoded test mode
  typedef enum logic [1:0] {
    TMS_NORMAL,
    TMS_COUNTER_SEG,
    TMS_SCAN_SHIFT,
    TMS_SCAN_CAPTURE
  } tms_mode_type;

  // Whole state of the top module
  typedef struct packed {
    logic [2:0]                     sync1;
    logic [2:0]                     sync2;
    logic [2:0]                     sync3;
    logic [2:0]                     pins;
    tms_mode_type                   mode;
    logic [`TMS_CHAIN_LEN-1:0]      chain;
    logic [`TMS_CNT_W-1:0]          pdata_in;
    logic                           pbus_oe;
  } tms_top_state_type;

endpackage

/* File: tms_regs.svh */
// Constants of the test-mode block: scan chain layout, mode codes, widths.
// Assumes inclusion by bare name from the test-mode package and modules.
// Function
// R1: Test mode splits counters into 4-bit slices
// R2: Slices count together, full cycle in 16
// R3: Tester owns the clock; factory use only
// R4: Boundary scan links I/O latches into chain
// R5: Shift in, capture once, shift out
// R6: Serial in on select bit 0, out pin
// R7: Clocks, control and status pins stay unscanned
// R8: Only processor bus outputs join the chain
// R9: Chain order fixed, receive symbols first
// R10: Test control lives in self-test block
// R11: Outside test, full counters, plain latches
`ifndef TMS_REGS_SVH
`define TMS_REGS_SVH

// Mode select pins, bits 2..1 (bit 0 carries scan data)
`define TMS_SEL_NORMAL     2'h0
`define TMS_SEL_COUNTER    2'h1
`define TMS_SEL_SCAN_SHIFT 2'h2
`define TMS_SEL_SCAN_CAPT  2'h3

// Counter geometry
`define TMS_CNT_W          16
`define TMS_SLICE_W        4

// Scan chain positions, position 0 is next to the serial input
`define TMS_CHAIN_LEN      49
`define TMS_POS_RSYM       0
`define TMS_POS_TXOFF      5
`define TMS_POS_TSYM       6
`define TMS_POS_TPAIR      11
`define TMS_POS_PAR_IN     21
`define TMS_POS_PAR_OUT    22
`define TMS_POS_RPAIR      23
`define TMS_POS_PBUS       33
// Cells that latch pins rather than drive them
`define TMS_INPUT_MASK     49'h0_0000_003F_F81F

`endif

/* File: tms_seg_counter.sv */
// Counter that splits into independent slices in segmentation mode.
// Assumes WIDTH is a whole multiple of SLICE_W; single clock domain.
`timescale 1ns/1ps
`include "tms_regs.svh"
module tms_seg_counter #(
  parameter int WIDTH   = `TMS_CNT_W,
  parameter int SLICE_W = `TMS_SLICE_W
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             seg_mode_in,
  input  wire logic             count_en_in,
  input  wire logic             clear_in,
  output logic [WIDTH-1:0]      value_out
);

  localparam int SLICES = WIDTH / SLICE_W;

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic [4:0]       run;
  } tms_cnt_state_type;

  tms_cnt_state_type st;
  tms_cnt_state_type next_st;

  // Slice increment, wraps inside the slice
  function automatic logic [SLICE_W-1:0] slice_inc(input logic [SLICE_W-1:0] v);
    slice_inc = SLICE_W'(v + 1'b1);
  endfunction

  // Next count; carries are cut at slice borders only in segmentation mode
  always_comb begin
    next_st = st;
    if (clear_in) begin
      next_st.count = '0;
    end else if (count_en_in) begin
      if (seg_mode_in) begin
        for (int s = 0; s < SLICES; s++) begin
          next_st.count[s*SLICE_W +: SLICE_W] = slice_inc(st.count[s*SLICE_W +: SLICE_W]); // R1 R2
        end
      end else begin
        next_st.count = WIDTH'(st.count + 1'b1); // R11
      end
    end
    // Run length of uninterrupted segmented counting, for checking only
    if (seg_mode_in && count_en_in && !clear_in) begin
      next_st.run = (st.run == 5'h10) ? st.run : 5'(st.run + 1'b1);
    end else begin
      next_st.run = 5'h0;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign value_out = st.count;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Second slice steps every count in segmentation mode
  slice_step_a: assert property ( // R1
    seg_mode_in && count_en_in && !clear_in |=> st.count[2*SLICE_W-1:SLICE_W] ==
      SLICE_W'($past(st.count[2*SLICE_W-1:SLICE_W]) + 1'b1))
    else $error("slice did not step on its own");

  // Sixteen segmented counts bring every slice back
  seg_cycle_a: assert property ( // R2
    st.run == 5'h10 |-> st.count == $past(st.count, 16))
    else $error("segmented count not back after 16 cycles");

  // Full width mode keeps the upper slice until the low slice wraps
  full_carry_a: assert property ( // R11
    !seg_mode_in && count_en_in && !clear_in && st.count[SLICE_W-1:0] != '1
      |=> st.count[WIDTH-1:SLICE_W] == $past(st.count[WIDTH-1:SLICE_W]))
    else $error("carry leaked in full width mode");

endmodule

/* File: tms_test_ctrl.sv */
// Test-mode control: boundary scan chain over the I/O latches and
// counter segmentation for a demonstration timer.
// Assumes one clock, data pins timed to it, mode pins asynchronous.
`timescale 1ns/1ps
`include "tms_regs.svh"
module tms_test_ctrl #(
  parameter int CNT_WIDTH = `TMS_CNT_W
) (
  input  wire logic                 CORE_CLK_IN,
  input  wire logic                 RST_N_IN,
  input  wire logic [2:0]           TEST_MODE_SELECT_PINS_IN,
  output logic                      SCAN_SERIAL_OUT,
  input  wire logic [4:0]           RECEIVE_SYMBOL_IN,
  output logic [4:0]                RECEIVE_SYMBOL_CORE_OUT,
  input  wire logic                 OPTICAL_TX_OFF_CORE_IN,
  output logic                      OPTICAL_TRANSMITTER_OFF_OUT,
  input  wire logic [4:0]           TRANSMIT_SYMBOL_CORE_IN,
  output logic [4:0]                TRANSMIT_SYMBOL_OUT,
  input  wire logic [9:0]           TRANSMIT_PAIR_IN,
  output logic [9:0]                TRANSMIT_PAIR_CORE_OUT,
  input  wire logic                 RECEIVE_PAIR_PARITY_IN,
  output logic                      RECEIVE_PAIR_PARITY_CORE_OUT,
  input  wire logic                 RECEIVE_PAIR_PARITY_CORE_IN,
  output logic                      RECEIVE_PAIR_PARITY_OUT,
  input  wire logic [9:0]           RECEIVE_PAIR_CORE_IN,
  output logic [9:0]                RECEIVE_PAIR_OUT,
  input  wire logic [15:0]          PROC_DATA_CORE_IN,
  input  wire logic                 PROC_DATA_OE_CORE_IN,
  output logic [15:0]               PROCESSOR_DATA_BUS_OUT,
  output logic                      PROCESSOR_DATA_BUS_OE_OUT,
  input  wire logic [15:0]          PROCESSOR_DATA_BUS_IN,
  output logic [15:0]               PROC_DATA_CORE_OUT,
  input  wire logic                 COUNT_EN_IN,
  input  wire logic                 COUNT_CLR_IN,
  output logic [CNT_WIDTH-1:0]      COUNT_VALUE_OUT,
  output logic                      COUNTER_SEG_MODE_OUT,
  output logic                      SCAN_MODE_OUT
);

  tms_pkg::tms_top_state_type st;
  tms_pkg::tms_top_state_type next_st;
  logic [`TMS_CHAIN_LEN-1:0]  func_vec;

  // Mode pins decoded to a mode
  function automatic tms_pkg::tms_mode_type decode_mode(input logic [1:0] sel);
    case (sel)
      `TMS_SEL_COUNTER:    decode_mode = tms_pkg::TMS_COUNTER_SEG;
      `TMS_SEL_SCAN_SHIFT: decode_mode = tms_pkg::TMS_SCAN_SHIFT;
      `TMS_SEL_SCAN_CAPT:  decode_mode = tms_pkg::TMS_SCAN_CAPTURE;
      default:             decode_mode = tms_pkg::TMS_NORMAL;
    endcase
  endfunction

  // Functional value of every cell, laid out in chain order; clocks,
  // status and control pins and the mode pins have no cell at all
  always_comb begin
    func_vec = '0; // R7
    for (int k = 0; k < 5; k++) begin
      func_vec[`TMS_POS_RSYM + k] = RECEIVE_SYMBOL_IN[k]; // R9
      func_vec[`TMS_POS_TSYM + k] = TRANSMIT_SYMBOL_CORE_IN[4-k]; // R9
    end
    func_vec[`TMS_POS_TXOFF] = OPTICAL_TX_OFF_CORE_IN;
    for (int k = 0; k < 10; k++) begin
      func_vec[`TMS_POS_TPAIR + k] = TRANSMIT_PAIR_IN[k]; // R9
      func_vec[`TMS_POS_RPAIR + k] = RECEIVE_PAIR_CORE_IN[9-k]; // R9
    end
    func_vec[`TMS_POS_PAR_IN]  = RECEIVE_PAIR_PARITY_IN;
    func_vec[`TMS_POS_PAR_OUT] = RECEIVE_PAIR_PARITY_CORE_IN;
    for (int k = 0; k < 16; k++) begin
      func_vec[`TMS_POS_PBUS + k] = PROC_DATA_CORE_IN[15-k]; // R8 R9
    end
  end

  // Next state: pin synchroniser, mode, chain cells, unscanned latches
  always_comb begin
    next_st = st;
    next_st.sync1 = TEST_MODE_SELECT_PINS_IN;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    // A pin change only counts once two stages agree
    if (st.sync2 == st.sync3) begin
      next_st.pins = st.sync3;
      next_st.mode = decode_mode(st.sync3[2:1]); // R10
    end
    case (st.mode)
      tms_pkg::TMS_SCAN_SHIFT: begin
        next_st.chain = {st.chain[`TMS_CHAIN_LEN-2:0], st.pins[0]}; // R4 R5 R6
      end
      tms_pkg::TMS_SCAN_CAPTURE: begin
        // Output cells hold the shifted pattern so the board sees it
        next_st.chain = (func_vec & `TMS_INPUT_MASK) | (st.chain & ~`TMS_INPUT_MASK); // R5
      end
      default: begin
        next_st.chain = func_vec; // R11
      end
    endcase
    // Data bus input side never joins the chain
    next_st.pdata_in = PROCESSOR_DATA_BUS_IN; // R8
    // Scan modes drive the bus so the interconnect can be observed
    next_st.pbus_oe = (st.mode == tms_pkg::TMS_SCAN_SHIFT || st.mode == tms_pkg::TMS_SCAN_CAPTURE)
                      ? 1'b1 : PROC_DATA_OE_CORE_IN;
  end

  // State register
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Pins and core side taken straight from the cell flops
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      RECEIVE_SYMBOL_CORE_OUT[k] = st.chain[`TMS_POS_RSYM + k];
      TRANSMIT_SYMBOL_OUT[4-k]   = st.chain[`TMS_POS_TSYM + k];
    end
    for (int k = 0; k < 10; k++) begin
      TRANSMIT_PAIR_CORE_OUT[k] = st.chain[`TMS_POS_TPAIR + k];
      RECEIVE_PAIR_OUT[9-k]     = st.chain[`TMS_POS_RPAIR + k];
    end
    for (int k = 0; k < 16; k++) begin
      PROCESSOR_DATA_BUS_OUT[15-k] = st.chain[`TMS_POS_PBUS + k];
    end
  end

  assign OPTICAL_TRANSMITTER_OFF_OUT  = st.chain[`TMS_POS_TXOFF];
  assign RECEIVE_PAIR_PARITY_CORE_OUT = st.chain[`TMS_POS_PAR_IN];
  assign RECEIVE_PAIR_PARITY_OUT      = st.chain[`TMS_POS_PAR_OUT];
  assign SCAN_SERIAL_OUT              = st.chain[`TMS_CHAIN_LEN-1]; // R6
  assign PROCESSOR_DATA_BUS_OE_OUT    = st.pbus_oe;
  assign PROC_DATA_CORE_OUT           = st.pdata_in;
  assign COUNTER_SEG_MODE_OUT         = (st.mode == tms_pkg::TMS_COUNTER_SEG);
  assign SCAN_MODE_OUT                = (st.mode == tms_pkg::TMS_SCAN_SHIFT) ||
                                        (st.mode == tms_pkg::TMS_SCAN_CAPTURE);

  // Demonstration timer; the tester is expected to pace the clock itself
  tms_seg_counter #(
    .WIDTH   (CNT_WIDTH),
    .SLICE_W (`TMS_SLICE_W)
  ) u_timer (
    .clk_in      (CORE_CLK_IN),
    .rst_n_in    (RST_N_IN),
    .seg_mode_in (COUNTER_SEG_MODE_OUT), // R1 R3
    .count_en_in (COUNT_EN_IN),
    .clear_in    (COUNT_CLR_IN),
    .value_out   (COUNT_VALUE_OUT)
  );

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  // Checks read the state flops, so each compares with inputs one edge back;
  // reset aborts them because the synchroniser clears along with the chain

  sequence shift_two_s;
    st.mode == tms_pkg::TMS_SCAN_SHIFT ##1 st.mode == tms_pkg::TMS_SCAN_SHIFT;
  endsequence

  sequence normal_two_s;
    st.mode == tms_pkg::TMS_NORMAL ##1 st.mode == tms_pkg::TMS_NORMAL;
  endsequence

  // Mode moves only after two synchroniser stages agreed
  mode_sync_a: assert property ( // R10
    $changed(st.mode) |-> $past(st.sync2) == $past(st.sync3))
    else $error("mode changed on unsettled pins");

  // Serial input lands in the first cell
  shift_in_a: assert property ( // R6
    st.mode == tms_pkg::TMS_SCAN_SHIFT |=> st.chain[0] == $past(st.pins[0]))
    else $error("scan input not taken from select bit 0");

  // Transmitter-off cell follows the last receive symbol cell
  chain_order_a: assert property ( // R9
    st.mode == tms_pkg::TMS_SCAN_SHIFT |=> st.chain[`TMS_POS_TXOFF] == $past(st.chain[`TMS_POS_RSYM + 4]))
    else $error("chain order broken after receive symbols");

  // Two shifts move a bit from cell 46 to the serial output
  shift_out_a: assert property ( // R4
    shift_two_s |=> SCAN_SERIAL_OUT == $past(st.chain[`TMS_CHAIN_LEN-3], 2))
    else $error("scan output lags the chain");

  // Capture keeps the driven pattern on the bus pins
  capture_hold_a: assert property ( // R5
    st.mode == tms_pkg::TMS_SCAN_CAPTURE |=> PROCESSOR_DATA_BUS_OUT == $past(PROCESSOR_DATA_BUS_OUT))
    else $error("output cell lost its pattern during capture");

  // Capture latches the receive symbol pins
  capture_in_a: assert property ( // R5
    st.mode == tms_pkg::TMS_SCAN_CAPTURE |=> RECEIVE_SYMBOL_CORE_OUT == $past(RECEIVE_SYMBOL_IN))
    else $error("input cell missed the capture");

  // Bus input side is a plain latch in every mode
  bus_in_free_a: assert property ( // R8
    ##1 PROC_DATA_CORE_OUT == $past(PROCESSOR_DATA_BUS_IN))
    else $error("bus input side disturbed by test logic");

  // Normal mode latches pass core data one cycle late
  normal_pass_a: assert property ( // R11
    normal_two_s |-> RECEIVE_PAIR_OUT == $past(RECEIVE_PAIR_CORE_IN) &&
      PROCESSOR_DATA_BUS_OE_OUT == $past(PROC_DATA_OE_CORE_IN))
    else $error("normal latch path altered");

  // Scan modes keep the bus driven so the board sees the cells
  scan_bus_drive_a: assert property ( // R4
    SCAN_MODE_OUT |=> PROCESSOR_DATA_BUS_OE_OUT)
    else $error("bus not driven during scan");

  // Capture latches the transmit pair pins
  capture_pair_a: assert property ( // R5
    st.mode == tms_pkg::TMS_SCAN_CAPTURE |=> TRANSMIT_PAIR_CORE_OUT == $past(TRANSMIT_PAIR_IN))
    else $error("transmit pair cell missed the capture");

  // Capture latches the parity input pin
  capture_par_a: assert property ( // R5
    st.mode == tms_pkg::TMS_SCAN_CAPTURE |=> RECEIVE_PAIR_PARITY_CORE_OUT == $past(RECEIVE_PAIR_PARITY_IN))
    else $error("parity input cell missed the capture");

  // Transmit symbols pass unchanged outside the test modes
  normal_tsym_a: assert property ( // R11
    normal_two_s |-> TRANSMIT_SYMBOL_OUT == $past(TRANSMIT_SYMBOL_CORE_IN))
    else $error("transmit symbol latch path altered");

  // Counter test leaves the bus latches on their plain path
  seg_latch_a: assert property ( // R11
    st.mode == tms_pkg::TMS_COUNTER_SEG |=> PROCESSOR_DATA_BUS_OUT == $past(PROC_DATA_CORE_IN))
    else $error("bus latch path altered in counter test");

endmodule

/* File: tms_test_ctrl_tb_top.sv */
// Self-checking bench for the test-mode controller.
// Assumes tms_regs.svh on the include path; tester model drives mode pins.
`timescale 1ns/1ps
`include "tms_regs.svh"
module tms_test_ctrl_tb_top;
  logic        clk, rst_n, tx_off, par_in, par_core, oe_core, cnt_en, cnt_clr;
  logic [4:0]  rsym, tsym, rsym_c, tsym_o;
  logic [9:0]  tpair, rpair, tpair_c, rpair_o;
  logic [15:0] pdata, pbus_in, pbus_o, pdata_c, cnt_val;
  logic [2:0]  sel;
  logic        scan_out, txoff_o, par_c, par_o, pbus_oe, seg_mode, scan_mode;
  logic [48:0] got;
  int          n_fail, num_checks, k;

  tms_tester_model i_tester (.clk_in(clk), .select_pins_out(sel));
  tms_test_ctrl i_dut (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .TEST_MODE_SELECT_PINS_IN(sel), .SCAN_SERIAL_OUT(scan_out),
    .RECEIVE_SYMBOL_IN(rsym), .RECEIVE_SYMBOL_CORE_OUT(rsym_c), .OPTICAL_TX_OFF_CORE_IN(tx_off),
    .OPTICAL_TRANSMITTER_OFF_OUT(txoff_o), .TRANSMIT_SYMBOL_CORE_IN(tsym), .TRANSMIT_SYMBOL_OUT(tsym_o),
    .TRANSMIT_PAIR_IN(tpair), .TRANSMIT_PAIR_CORE_OUT(tpair_c), .RECEIVE_PAIR_PARITY_IN(par_in),
    .RECEIVE_PAIR_PARITY_CORE_OUT(par_c), .RECEIVE_PAIR_PARITY_CORE_IN(par_core),
    .RECEIVE_PAIR_PARITY_OUT(par_o), .RECEIVE_PAIR_CORE_IN(rpair), .RECEIVE_PAIR_OUT(rpair_o),
    .PROC_DATA_CORE_IN(pdata), .PROC_DATA_OE_CORE_IN(oe_core), .PROCESSOR_DATA_BUS_OUT(pbus_o),
    .PROCESSOR_DATA_BUS_OE_OUT(pbus_oe), .PROCESSOR_DATA_BUS_IN(pbus_in), .PROC_DATA_CORE_OUT(pdata_c),
    .COUNT_EN_IN(cnt_en), .COUNT_CLR_IN(cnt_clr), .COUNT_VALUE_OUT(cnt_val),
    .COUNTER_SEG_MODE_OUT(seg_mode), .SCAN_MODE_OUT(scan_mode)
  );

  // 25 MHz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [48:0] g, input logic [48:0] e, input string what);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Chain image worked out from the pins, position 0 nearest the serial input
  function automatic logic [48:0] exp_chain();
    logic [48:0] v;
    for (int i = 0; i < 5; i++) begin
      v[i] = rsym[i];
      v[10-i] = tsym[i];
    end
    for (int i = 0; i < 10; i++) begin
      v[11+i] = tpair[i];
      v[32-i] = rpair[i];
    end
    for (int i = 0; i < 16; i++) begin
      v[48-i] = pdata[i];
    end
    v[5] = tx_off;
    v[21] = par_in;
    v[22] = par_core;
    return v;
  endfunction

  // Distinct pattern on every pin group so swapped cells show up
  task automatic set_data(input logic [15:0] p);
    @(negedge clk);
    rsym = p[4:0];
    tsym = p[15:11];
    tx_off = p[5];
    tpair = p[9:0];
    rpair = ~p[15:6];
    par_in = p[6];
    par_core = ~p[6];
    pdata = p;
    pbus_in = ~p;
    oe_core = p[0];
  endtask

  // Mode takes effect on the fourth edge after the pin change
  task automatic go_mode(input logic [1:0] m);
    i_tester.set_mode(m);
    repeat (4) @(negedge clk);
  endtask

  // Last cell comes out first
  task automatic read_chain(output logic [48:0] v);
    for (int i = 0; i < `TMS_CHAIN_LEN; i++) begin
      v[48-i] = scan_out;
      @(negedge clk);
    end
  endtask

  task automatic count(input int n);
    @(negedge clk);
    cnt_en = 1'b1;
    repeat (n) @(negedge clk);
    cnt_en = 1'b0;
  endtask

  task automatic clear_count();
    @(negedge clk);
    cnt_clr = 1'b1;
    @(negedge clk);
    cnt_clr = 1'b0;
  endtask

  task automatic t_normal();
    set_data(16'ha5c3);
    @(negedge clk);
    check({rsym_c, txoff_o, tsym_o, tpair_c, par_c, par_o, rpair_o}, {rsym, tx_off, tsym, tpair, par_in, par_core, rpair}, "pipe");
    check({pbus_o, pdata_c, pbus_oe}, {pdata, pbus_in, oe_core}, "bus pipe");
  endtask

  task automatic t_shift_out();
    go_mode(2'h2);
    check({scan_mode, seg_mode, pbus_oe}, 3'h5, "scan flags");
    read_chain(got);
    check(got, exp_chain(), "chain order");
  endtask

  task automatic t_serial_in();
    i_tester.set_bit(1'b1);
    k = 0;
    while (scan_out !== 1'b1 && k < 70) begin
      @(negedge clk);
      k++;
    end
    // Four edges through the synchroniser, one into cell 0, 48 to the end
    check(k == 4 + `TMS_CHAIN_LEN, 1, "serial in");
    i_tester.set_bit(1'b0);
    repeat (60) @(negedge clk);
    check(scan_out, 0, "flush");
  endtask

  task automatic t_capture();
    set_data(16'h3c96);
    go_mode(2'h3);
    // Core enable is low here, so a driven bus shows the scan override
    check({scan_mode, pbus_oe}, 2'h3, "capture flag");
    go_mode(2'h2);
    read_chain(got);
    check(got, exp_chain() & `TMS_INPUT_MASK, "captured");
  endtask

  task automatic t_counter();
    go_mode(2'h0);
    clear_count();
    check(pbus_oe, oe_core, "bus enable back");
    count(17);
    check(cnt_val, 16'h0011, "full count");
    go_mode(2'h1);
    check({seg_mode, scan_mode}, 2'h2, "seg flag");
    clear_count();
    count(17);
    check(cnt_val, 16'h1111, "slices");
    count(15);
    check(cnt_val, 16'h0000, "slice wrap");
  endtask

  initial begin
    {rst_n, tx_off, par_in, par_core, oe_core, cnt_en, cnt_clr} = 7'h00;
    {rsym, tsym, tpair, rpair, pdata, pbus_in} = 62'h0;
    n_fail = 0;
    num_checks = 0;
    repeat (6) @(negedge clk);
    check({cnt_val, pbus_o, scan_out}, 0, "reset");
    rst_n = 1'b1;
    t_normal();
    t_shift_out();
    t_serial_in();
    t_capture();
    t_counter();
    final_report();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #(20000 * 40);
    n_fail++;
    final_report();
  end
endmodule

/* File: tms_tester_model.sv */
// Board tester model: drives the mode select pins and the scan data bit.
// Assumes the bench calls its tasks; pins change only at falling edges.
`timescale 1ns/1ps
module tms_tester_model (
  input  wire logic  clk_in,
  output logic [2:0] select_pins_out
);
  // Idle in normal mode, scan data low
  initial begin
    select_pins_out = 3'h0;
  end

  // Mode change one edge at a time; tester follows the bench clock on clk_in
  task automatic set_mode(input logic [1:0] mode);
    @(negedge clk_in);
    select_pins_out[2:1] = mode;
  endtask

  // Serial data rides on select bit 0
  task automatic set_bit(input logic b);
    @(negedge clk_in);
    select_pins_out[0] = b;
  endtask
endmodule
